// *** psmr_host.sv ***
/* Host model: issues one-byte command reads and writes to the register group.
 Assumes it shares clk_sys with the register group. */
`timescale 1ns/1ns
`default_nettype none
module psmr_host (
    input  wire logic       clk_sys,
    input  wire logic [7:0] cmd_rdata,
    output logic      [7:0] cmd_code,
    output logic            cmd_write,
    output logic            cmd_read,
    output logic      [7:0] cmd_wdata
);
    initial {cmd_code, cmd_write, cmd_read, cmd_wdata} = 18'h0;
    // One strobe cycle, then idle data flips so stale bytes never look valid
    task automatic xfer(input logic w, input logic [7:0] c, d, output logic [7:0] q);
        @(posedge clk_sys);
        {cmd_code, cmd_write, cmd_read, cmd_wdata} <= {c, w, !w, d};
        @(posedge clk_sys);
        {cmd_write, cmd_read, cmd_wdata} <= {2'h0, ~d};
        #1 q = cmd_rdata;
    endtask : xfer
endmodule : psmr_host
`default_nettype wire

// *** psmr_pkg.sv ***
/*
 Package for the port status and mode register group: command codes,
 field positions, reset values, mode encodings and carrier structs.
 Assumes a command/data register port driven by a serial bus front end.
*/
`default_nettype none
package psmr_pkg;
    // ********************************
    // Command codes and layout
    // ********************************
    localparam logic [7:0] CMD_POWER_STATE = 8'h10;
    localparam logic [7:0] CMD_ADDR_READ   = 8'h11;
    localparam logic [7:0] CMD_MODE_SELECT = 8'h12;
    localparam logic [7:0] MODE_RESET      = 8'h00;
    localparam logic [7:0] STATE_RESET     = 8'h00;
    localparam int         NUM_PORTS       = 4;
    localparam int         PG_LSB          = 4;
    localparam int         ADDR_LSB        = 2;
    localparam logic [1:0] ADDR_FIXED      = 2'h1;
    localparam logic [6:0] ADDR_BROADCAST  = 7'h7f;

    typedef enum logic [1:0] {
        MODE_OFF    = 2'h0,
        MODE_MANUAL = 2'h1,
        MODE_SEMI_A = 2'h2,
        MODE_SEMI_B = 2'h3
    } psmr_mode_type;

    // Power-good in the upper nibble, on flags in the lower, as the host reads them
    typedef struct packed {
        logic [3:0] power_good_flags;
        logic [3:0] port_on_flags;
    } psmr_status_type;

    typedef struct packed {
        logic [7:0]      port_mode_select;
        psmr_status_type stat;
        logic [3:0]      strap_meta;
        logic [3:0]      strap_sync;
        logic [7:0]      rd_data;
    } psmr_state_type;
endpackage : psmr_pkg
`default_nettype wire

// *** psmr_regs.sv ***
/*
 Port power status, bus address readback and operating mode registers.
 Assumes port switching and drain sense come from on-chip logic on clk_sys,
 address straps come from pins, and the serial front end gives one-cycle
 read and write strobes with a command code.
*/
`timescale 1ns/1ns
`default_nettype none
module psmr_regs (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] cmd_code,
    input  wire logic       cmd_write,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_wdata,
    output logic      [7:0] cmd_rdata,
    input  wire logic [3:0] port_switched_on,
    input  wire logic [3:0] port_drain_sense,
    input  wire logic [3:0] address_strap_pins,
    input  wire logic       config_b,
    input  wire logic       addr_low_internal,
    output logic      [3:0] port_mode_off,
    output logic      [3:0] port_mode_manual,
    output logic      [3:0] port_mode_semi,
    output logic      [6:0] bus_address_bits,
    output logic            broadcast_match_en
);
    // ********************************
    // Helpers
    // ********************************
    function automatic psmr_pkg::psmr_mode_type mode_of(input logic [7:0] reg_v, input int p);
        mode_of = psmr_pkg::psmr_mode_type'(reg_v[2*p +: 2]);
    endfunction : mode_of

    // True when a strobe carries the given command code
    function automatic logic cmd_hit(input logic strobe, input logic [7:0] code, input logic [7:0] target);
        cmd_hit = strobe && (code == target);
    endfunction : cmd_hit

    // Power-good clears on switch-off, sets on low drain, otherwise keeps its value
    function automatic logic pg_next(input logic on_eff, input logic drain_low, input logic pg_now);
        if (!on_eff) begin
            pg_next = 1'b0;
        end else if (drain_low) begin
            pg_next = 1'b1;
        end else begin
            pg_next = pg_now;
        end
    endfunction : pg_next

    // Own address: fixed 01, four strap levels, internal low bit (forced to 0 when config_b is set)
    function automatic logic [6:0] form_addr(input logic [3:0] straps, input logic low_bit, input logic cfg_b);
        form_addr = {psmr_pkg::ADDR_FIXED, straps, low_bit & ~cfg_b};
    endfunction : form_addr

    // Read data for one command code; unmapped codes read as zero
    function automatic logic [7:0] read_mux(
        input logic [7:0]                code,
        input psmr_pkg::psmr_status_type stat,
        input logic [6:0]                addr,
        input logic [7:0]                mode
    );
        if (code == psmr_pkg::CMD_POWER_STATE) begin
            read_mux = stat;
        end else if (code == psmr_pkg::CMD_ADDR_READ) begin
            read_mux = {1'b0, addr[4:0], 2'h0};
        end else if (code == psmr_pkg::CMD_MODE_SELECT) begin
            read_mux = mode;
        end else begin
            read_mux = 8'h00;
        end
    endfunction : read_mux

    psmr_pkg::psmr_state_type st;
    psmr_pkg::psmr_state_type next_st;
    logic [3:0] port_on_eff;
    logic [6:0] own_addr;

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        next_st = st;
        next_st.strap_meta = address_strap_pins;
        next_st.strap_sync = st.strap_meta;
        // Only the mode register takes writes; writes to the status codes are dropped
        if (cmd_hit(cmd_write, cmd_code, psmr_pkg::CMD_MODE_SELECT)) begin
            next_st.port_mode_select = cmd_wdata;
        end
        for (int p = 0; p < psmr_pkg::NUM_PORTS; p++) begin
            port_on_eff[p] = port_switched_on[p] && mode_of(st.port_mode_select, p) != psmr_pkg::MODE_OFF;
            next_st.stat.port_on_flags[p] = port_on_eff[p];
            next_st.stat.power_good_flags[p] = pg_next(port_on_eff[p], port_drain_sense[p],
                                                       st.stat.power_good_flags[p]);
        end
        own_addr = form_addr(st.strap_sync, addr_low_internal, config_b);
        if (cmd_read) begin
            next_st.rd_data = read_mux(cmd_code, st.stat, own_addr, st.port_mode_select);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
            st.port_mode_select <= psmr_pkg::MODE_RESET;
            st.stat <= psmr_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    always_comb begin
        for (int p = 0; p < psmr_pkg::NUM_PORTS; p++) begin
            port_mode_off[p]    = mode_of(st.port_mode_select, p) == psmr_pkg::MODE_OFF;
            port_mode_manual[p] = mode_of(st.port_mode_select, p) == psmr_pkg::MODE_MANUAL;
            port_mode_semi[p]   = st.port_mode_select[2*p+1];
        end
    end
    assign cmd_rdata          = st.rd_data;
    assign bus_address_bits   = own_addr;
    assign broadcast_match_en = 1'b1;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    pg_needs_on_a: assert property (st.stat.power_good_flags[0] |-> st.stat.port_on_flags[0])
        else $error("power good set while port off");
    pg_set_a: assert property (port_on_eff[1] && port_drain_sense[1] |=> st.stat.power_good_flags[1])
        else $error("power good not set");
    pg_latch_a: assert property (st.stat.power_good_flags[2] && port_on_eff[2] |=> st.stat.power_good_flags[2])
        else $error("power good dropped while on");
    on_follow_a: assert property (##1 st.stat.port_on_flags == $past(port_on_eff))
        else $error("on flags do not follow ports");
    addr_read_a: assert property (cmd_read && cmd_code == 8'h11 |=> cmd_rdata[7] == 1'b0 && cmd_rdata[1:0] == 2'h0)
        else $error("address readback reserved bits set");
    cfgb_low_a: assert property (config_b |-> bus_address_bits[0] == 1'b0)
        else $error("config b low bit not zero");
    addr_form_a: assert property (##2 bus_address_bits[6:1] == {2'h1, $past(address_strap_pins, 2)})
        else $error("bus address wrong");
    mode_wr_a: assert property (cmd_write && cmd_code == 8'h12 |=> st.port_mode_select == $past(cmd_wdata))
        else $error("mode write lost");
    off_mode_a: assert property (port_mode_off[3] |=> !st.stat.port_on_flags[3])
        else $error("port on in off mode");
    semi_dec_a: assert property (st.port_mode_select[1] |-> port_mode_semi[0] && !port_mode_manual[0])
        else $error("semi decode wrong");

    // ********************************
    // Status checks
    // ********************************
    pg_clear_a: assert property (!port_on_eff[0] |=> !st.stat.power_good_flags[0])
        else $error("power good kept after switch-off");
    rd_hold_a: assert property (!cmd_read |=> $stable(cmd_rdata))
        else $error("read data changed without a read");
    state_rd_a: assert property (
        cmd_hit(cmd_read, cmd_code, psmr_pkg::CMD_POWER_STATE) |=> cmd_rdata == $past(st.stat))
        else $error("status readback wrong");
    pg_no_set_a: assert property (
        !st.stat.power_good_flags[3] && !port_drain_sense[3] |=> !st.stat.power_good_flags[3])
        else $error("power good set without low drain");
    on_zero_a: assert property (!port_switched_on[2] |=> !st.stat.port_on_flags[2])
        else $error("on flag set for a switched-off port");

    // ********************************
    // Address checks
    // ********************************
    addr_rd_val_a: assert property (
        cmd_hit(cmd_read, cmd_code, psmr_pkg::CMD_ADDR_READ) |=> cmd_rdata[6:2] == $past(bus_address_bits[4:0]))
        else $error("address readback bits wrong");
    addr_low_a: assert property (!config_b |-> bus_address_bits[0] == addr_low_internal)
        else $error("internal low address bit lost");
    addr_fixed_a: assert property (
        bus_address_bits[6:5] == psmr_pkg::ADDR_FIXED && bus_address_bits != psmr_pkg::ADDR_BROADCAST)
        else $error("fixed address bits wrong");
    bcast_en_a: assert property (broadcast_match_en)
        else $error("broadcast answer disabled");

    // ********************************
    // Mode checks
    // ********************************
    mode_rd_a: assert property (
        cmd_hit(cmd_read, cmd_code, psmr_pkg::CMD_MODE_SELECT) |=> cmd_rdata == $past(st.port_mode_select))
        else $error("mode readback wrong");
    mode_keep_a: assert property (
        !cmd_hit(cmd_write, cmd_code, psmr_pkg::CMD_MODE_SELECT) |=> $stable(st.port_mode_select))
        else $error("mode changed without a write");
    reset_val_a: assert property (
        $fell(rst) |-> st.port_mode_select == psmr_pkg::MODE_RESET && st.stat == psmr_pkg::STATE_RESET)
        else $error("register group not cleared by reset");
    off_pg_a: assert property (port_mode_off[1] |=> !st.stat.power_good_flags[1])
        else $error("power good set in off mode");
    manual_dec_a: assert property (
        st.port_mode_select[3:2] == 2'h1 |-> port_mode_manual[1] && !port_mode_off[1] && !port_mode_semi[1])
        else $error("manual decode wrong");
    off_dec_a: assert property (
        st.port_mode_select[5:4] == 2'h0 |-> port_mode_off[2] && !port_mode_manual[2] && !port_mode_semi[2])
        else $error("off decode wrong");

    // ********************************
    // Coverage
    // ********************************
    pg_seen_c: cover property (st.stat.power_good_flags[0] ##1 !st.stat.power_good_flags[0]);
    mode_wr_c: cover property (cmd_write && cmd_code == 8'h12);
    addr_rd_c: cover property (cmd_read && cmd_code == 8'h11);
    pg_hold_c: cover property (st.stat.power_good_flags[0] && !port_drain_sense[0]);
    off_on_c: cover property (port_mode_off[2] && port_switched_on[2]);
endmodule : psmr_regs
`default_nettype wire

// *** psmr_regs_tb.sv ***
/* Self-checking bench for the port status and mode registers.
 Assumes psmr_pkg, psmr_regs and psmr_host are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module psmr_regs_tb;
    logic       clk_sys = 0, rst = 1, cmd_write, cmd_read, config_b = 0, addr_low_internal = 1;
    logic       broadcast_match_en;
    logic [7:0] cmd_code, cmd_wdata, cmd_rdata, q;
    logic [3:0] port_switched_on = 4'h0, port_drain_sense = 4'h0, address_strap_pins = 4'h0;
    logic [3:0] port_mode_off, port_mode_manual, port_mode_semi;
    logic [6:0] bus_address_bits;
    int         error_cnt = 0, compares = 0, cyc = 0;
    always #25 clk_sys = ~clk_sys;
    psmr_regs DUT (.clk_sys, .rst, .cmd_code, .cmd_write, .cmd_read, .cmd_wdata, .cmd_rdata,
        .port_switched_on, .port_drain_sense, .address_strap_pins, .config_b, .addr_low_internal,
        .port_mode_off, .port_mode_manual, .port_mode_semi, .bus_address_bits, .broadcast_match_en);
    psmr_host HOST (.clk_sys, .cmd_rdata, .cmd_code, .cmd_write, .cmd_read, .cmd_wdata);
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] c);
        HOST.xfer(1'b0, c, 8'h00, q);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : settle
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset;
        rd(psmr_pkg::CMD_POWER_STATE); chk("state", 8'h00, q);
        rd(psmr_pkg::CMD_MODE_SELECT); chk("mode", 8'h00, q);
        rd(8'h13); chk("unmapped", 8'h00, q);
        $display("reset values done");
    endtask : t_reset
    task automatic t_mode;
        HOST.xfer(1'b1, psmr_pkg::CMD_MODE_SELECT, 8'he4, q);
        chk("off", 8'h01, 8'(port_mode_off));
        chk("manual", 8'h02, 8'(port_mode_manual));
        chk("semi", 8'h0c, 8'(port_mode_semi));
        rd(psmr_pkg::CMD_MODE_SELECT); chk("mode rd", 8'he4, q);
        HOST.xfer(1'b1, psmr_pkg::CMD_POWER_STATE, 8'hff, q);
        rd(psmr_pkg::CMD_MODE_SELECT); chk("mode kept", 8'he4, q);
        rd(psmr_pkg::CMD_POWER_STATE); chk("ro state", 8'h00, q);
        $display("mode decode done");
    endtask : t_mode
    task automatic t_status;
        HOST.xfer(1'b1, psmr_pkg::CMD_MODE_SELECT, 8'h55, q);
        settle(1);
        port_switched_on <= 4'h5;
        port_drain_sense <= 4'h1;
        settle(4); rd(psmr_pkg::CMD_POWER_STATE); chk("on pg", 8'h15, q);
        settle(1);
        port_drain_sense <= 4'h0;
        settle(4); rd(psmr_pkg::CMD_POWER_STATE); chk("pg held", 8'h15, q);
        settle(1);
        port_switched_on <= 4'h4;
        settle(4); rd(psmr_pkg::CMD_POWER_STATE); chk("port off", 8'h04, q);
        HOST.xfer(1'b1, psmr_pkg::CMD_MODE_SELECT, 8'h45, q);
        settle(4); rd(psmr_pkg::CMD_POWER_STATE); chk("mode off", 8'h00, q);
        $display("power status done");
    endtask : t_status
    task automatic t_rerun;
        HOST.xfer(1'b1, psmr_pkg::CMD_MODE_SELECT, 8'h55, q);
        settle(1);
        port_switched_on <= 4'h1;
        port_drain_sense <= 4'h1;
        settle(4); rd(psmr_pkg::CMD_POWER_STATE); chk("before rst", 8'h11, q);
        settle(1);
        rst <= 1'b1;
        settle(2);
        rst <= 1'b0;
        rd(psmr_pkg::CMD_POWER_STATE); chk("rst state", 8'h00, q);
        rd(psmr_pkg::CMD_MODE_SELECT); chk("rst mode", 8'h00, q);
        settle(1);
        port_switched_on <= 4'h0;
        port_drain_sense <= 4'h0;
        $display("mid-run reset done");
    endtask : t_rerun
    task automatic t_addr;
        for (int i = 0; i < 32; i += 5) begin
            settle(1);
            address_strap_pins <= 4'(i);
            config_b           <= i[4];
            addr_low_internal  <= i[0];
            settle(4);
            chk("addr", {1'b0, psmr_pkg::ADDR_FIXED, 4'(i), i[0] & !i[4]}, 8'(bus_address_bits));
            rd(psmr_pkg::CMD_ADDR_READ); chk("addr rd", {1'b0, 4'(i), i[0] & !i[4], 2'h0}, q);
        end
        chk("bcast", 8'h01, 8'(broadcast_match_en));
        $display("address readback done");
    endtask : t_addr
    initial begin
        settle(6);
        rst <= 1'b0;
        t_reset();
        t_mode();
        t_status();
        t_rerun();
        t_addr();
        end_of_test();
    end
endmodule : psmr_regs_tb
`default_nettype wire
